// ==== rtl/evt_irq.v ====
// Sticky event bits, write-one-to-clear, with mask and level interrupt.
// Assumes the event inputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_host_regs.vh"

module evt_irq (
    input wire core_clk,
    input wire nrst,
    input wire [`EV_W-1:0] evSet,
    input wire clrWrite,
    input wire maskWrite,
    input wire [`EV_W-1:0] wdata,
    output reg [`EV_W-1:0] evStat,
    output reg [`EV_W-1:0] evMask,
    output reg irq
);

always @(posedge core_clk) begin
    if (!nrst) begin
        evStat <= {`EV_W{1'b0}};
        evMask <= {`EV_W{1'b0}};
        irq <= 1'b0;
    end else begin
        // Set wins over a clear in the same cycle
        evStat <= (evStat & ~(clrWrite ? wdata : {`EV_W{1'b0}})) | evSet;
        if (maskWrite) begin
            evMask <= wdata;
        end
        irq <= |(evStat & evMask);
    end
end

endmodule // evt_irq
`default_nettype wire

// ==== rtl/nand_pin_cycle.v ====
// One flash bus cycle: command, address, data write or data read.
// Assumes chip enable is held low by the caller around the cycle.
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_host_regs.vh"

module nand_pin_cycle (
    input wire core_clk,
    input wire nrst,
    input wire start,
    input wire [1:0] kind,
    input wire [7:0] wrByte,
    output reg done,
    output reg [7:0] rdByte,
    output reg cmdLatch,
    output reg addrLatch,
    output reg writeStrobeN,
    output reg readStrobeN,
    output reg [7:0] ioOut,
    output reg ioOe,
    input wire [7:0] ioIn
);

localparam S_IDLE = 2'h0;
localparam S_LOW = 2'h1;
localparam S_HIGH = 2'h2;

reg [1:0] state_r;
reg [2:0] cnt_r;
reg isRead_r;

always @(posedge core_clk) begin
    if (!nrst) begin
        state_r <= S_IDLE;
        cnt_r <= 3'h0;
        isRead_r <= 1'b0;
        done <= 1'b0;
        rdByte <= 8'h00;
        cmdLatch <= 1'b0;
        addrLatch <= 1'b0;
        writeStrobeN <= 1'b1;
        readStrobeN <= 1'b1;
        ioOut <= 8'h00;
        ioOe <= 1'b0;
    end else begin
        done <= 1'b0;
        case (state_r)
            S_IDLE: begin
                if (start) begin
                    cmdLatch <= (kind == `CYC_CMD);
                    addrLatch <= (kind == `CYC_ADDR);
                    isRead_r <= (kind == `CYC_RD);
                    if (kind == `CYC_RD) begin
                        readStrobeN <= 1'b0;
                        ioOe <= 1'b0;
                        cnt_r <= 3'(`RD_LOW_CYC - 1);
                    end else begin
                        writeStrobeN <= 1'b0;
                        ioOut <= wrByte;
                        ioOe <= 1'b1;
                        cnt_r <= 3'(`WR_LOW_CYC - 1);
                    end
                    state_r <= S_LOW;
                end
            end
            S_LOW: begin
                if (cnt_r == 3'h0) begin
                    // Sample after access time, then release strobe
                    if (isRead_r) begin
                        rdByte <= ioIn;
                    end
                    readStrobeN <= 1'b1;
                    writeStrobeN <= 1'b1;
                    cnt_r <= isRead_r ? 3'(`RD_HIGH_CYC - 1) : 3'(`WR_HIGH_CYC - 1);
                    state_r <= S_HIGH;
                end else begin
                    cnt_r <= cnt_r - 3'h1;
                end
            end
            S_HIGH: begin
                if (cnt_r == 3'h0) begin
                    cmdLatch <= 1'b0;
                    addrLatch <= 1'b0;
                    ioOe <= 1'b0;
                    done <= 1'b1;
                    state_r <= S_IDLE;
                end else begin
                    cnt_r <= cnt_r - 3'h1;
                end
            end
            default: begin
                state_r <= S_IDLE;
            end
        endcase
    end
end

endmodule // nand_pin_cycle
`default_nettype wire

// ==== rtl/nand_status_host.v ====
// Host controller that drives a parallel NAND flash through its pins,
// runs program, erase, reset and status sequences and reports results.
// Assumes pin inputs synchronous to core_clk; busy line pulled up outside.
//
// Overview of operation
// [RULE1] After 70h, read cycles return status
// [RULE2] Status polled without reissuing the command
// [RULE3] Status mode persists until another command
// [RULE4] Issue 00h before data reads after status
// [RULE5] Bit 0 gives current program/erase result
// [RULE6] Cache bit 0 valid only when bit5 set
// [RULE7] Bit 1 valid after second cache confirm
// [RULE8] Bit 5 set means no array operation
// [RULE9] Bit 6 ready means next command accepted
// [RULE10] Bit 7 low means block protected
// [RULE11] Busy line low while operation runs
// [RULE12] Busy line open-drain, wired-OR, pulled up
// [RULE13] Below lockout supply everything is disabled
// [RULE14] Wait recovery time after power-up
// [RULE15] Hold write protect low during power transitions
// [RULE16] Program and erase need setup plus confirm
// [RULE17] Host ignores status bits 2 to 4
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_host_regs.vh"

module nand_status_host (
    input wire core_clk,
    input wire nrst,
    input wire [2:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdata,
    output wire irq,
    output reg chipEnN,
    output wire cmdLatch,
    output wire addrLatch,
    output wire writeStrobeN,
    output wire readStrobeN,
    output reg wpN,
    output wire [7:0] ioOut,
    output wire ioOe,
    input wire [7:0] ioIn,
    input wire busyLine,
    input wire supplyOk
);

////////////////////////////////////////////////////////////////////////////////
// States

localparam ST_PWR = 4'h0;
localparam ST_IDLE = 4'h1;
localparam ST_CMD1 = 4'h2;
localparam ST_ADDR = 4'h3;
localparam ST_DATA = 4'h4;
localparam ST_CMD2 = 4'h5;
localparam ST_TWB = 4'h6;
localparam ST_RB = 4'h7;
localparam ST_SCMD = 4'h8;
localparam ST_SREAD = 4'h9;
localparam ST_RDCMD = 4'ha;
localparam ST_RDDATA = 4'hb;
localparam ST_DONE = 4'hc;

reg [3:0] state_r;
reg [3:0] state_nxt;
reg issued_r;
reg [2:0] op_r;
reg [2:0] addrIdx_r;
reg [15:0] col_r;
reg [23:0] row_r;
reg [7:0] data_r;
reg [7:0] flashSt_r;
reg statusMode_r;
reg cacheSeen_r;
reg prevValid_r;
reg wpRel_r;
reg pwrReady_r;
reg [10:0] pwrCnt_r;
reg [3:0] twbCnt_r;
reg [`EV_W-1:0] evSet;

wire cycDone;
wire [7:0] cycRd;
wire [`EV_W-1:0] evStat;
wire [`EV_W-1:0] evMask;

reg cycStart;
reg [1:0] cycKind;
reg [7:0] cycByte;

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [7:0] addrByte;
    input [2:0] idx;
    input [15:0] col;
    input [23:0] row;
    begin
        case (idx)
            3'h0: addrByte = col[7:0];
            3'h1: addrByte = col[15:8];
            3'h2: addrByte = row[7:0];
            3'h3: addrByte = row[15:8];
            default: addrByte = row[23:16];
        endcase
    end
endfunction

function [7:0] setupCode;
    input [2:0] op;
    begin
        case (op)
            `OP_RESET: setupCode = `CMD_RESET;
            `OP_ERASE: setupCode = `CMD_ERASE_SETUP;
            default: setupCode = `CMD_PROG_SETUP;
        endcase
    end
endfunction

wire isProgOp = (op_r == `OP_PROG) || (op_r == `OP_CACHE);
wire isArrayOp = isProgOp || (op_r == `OP_ERASE);
wire [2:0] addrLast = (op_r == `OP_ERASE) ? 3'h4 : 3'h4;
wire regWr = regWrite;

////////////////////////////////////////////////////////////////////////////////
// Pin cycle generator

nand_pin_cycle u_cycle (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(cycStart),
    .kind(cycKind),
    .wrByte(cycByte),
    .done(cycDone),
    .rdByte(cycRd),
    .cmdLatch(cmdLatch),
    .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN),
    .ioOut(ioOut),
    .ioOe(ioOe),
    .ioIn(ioIn)
);

always @* begin
    cycKind = `CYC_CMD;
    cycByte = 8'h00;
    case (state_r)
        ST_CMD1: cycByte = setupCode(op_r);
        ST_ADDR: begin
            cycKind = `CYC_ADDR;
            cycByte = addrByte(addrIdx_r, col_r, row_r);
        end
        ST_DATA: begin
            cycKind = `CYC_WR;
            cycByte = data_r;
        end
        ST_CMD2: begin
            if (op_r == `OP_ERASE) begin
                cycByte = `CMD_ERASE_CONF;
            end else if (op_r == `OP_CACHE) begin
                cycByte = `CMD_CACHE_CONF;
            end else begin
                cycByte = `CMD_PROG_CONF;
            end
        end
        ST_SCMD: cycByte = `CMD_STATUS;
        ST_RDCMD: cycByte = `CMD_READ;
        ST_SREAD: cycKind = `CYC_RD;
        ST_RDDATA: cycKind = `CYC_RD;
        default: cycKind = `CYC_CMD;
    endcase
    cycStart = !issued_r && (state_r == ST_CMD1 || state_r == ST_ADDR || state_r == ST_DATA ||
        state_r == ST_CMD2 || state_r == ST_SCMD || state_r == ST_SREAD ||
        state_r == ST_RDCMD || state_r == ST_RDDATA);
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

wire startReq = regWr && (regAddr == `REG_CTRL) && regWdata[`CTRL_START];

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_PWR: if (pwrReady_r) state_nxt = ST_IDLE;
        ST_IDLE: begin
            if (startReq) begin
                case (regWdata[`CTRL_OP_HI:`CTRL_OP_LO])
                    // Status mode kept: just read again
                    `OP_STATUS: state_nxt = statusMode_r ? ST_SREAD : ST_SCMD; // RULE3
                    `OP_DATARD: state_nxt = statusMode_r ? ST_RDCMD : ST_RDDATA; // RULE4
                    `OP_RESET, `OP_PROG, `OP_ERASE, `OP_CACHE: state_nxt = ST_CMD1;
                    default: state_nxt = ST_IDLE;
                endcase
            end
        end
        ST_CMD1: if (cycDone) state_nxt = (op_r == `OP_RESET) ? ST_TWB : ST_ADDR;
        ST_ADDR: if (cycDone && addrIdx_r == addrLast) state_nxt = isProgOp ? ST_DATA : ST_CMD2;
        ST_DATA: if (cycDone) state_nxt = ST_CMD2;
        ST_CMD2: if (cycDone) state_nxt = ST_TWB; // RULE16
        ST_TWB: if (twbCnt_r == 4'h0) state_nxt = ST_RB;
        ST_RB: if (busyLine) state_nxt = ST_SCMD; // RULE11 RULE12
        ST_SCMD: if (cycDone) state_nxt = ST_SREAD; // RULE1
        ST_SREAD: begin
            if (cycDone) begin
                // Cache: keep reading until a new command is accepted
                if (op_r == `OP_CACHE && !cycRd[`ST_READY]) begin // RULE9
                    state_nxt = ST_SREAD; // RULE2
                end else begin
                    state_nxt = ST_DONE;
                end
            end
        end
        ST_RDCMD: if (cycDone) state_nxt = ST_RDDATA;
        ST_RDDATA: if (cycDone) state_nxt = ST_DONE;
        ST_DONE: state_nxt = ST_IDLE;
        default: state_nxt = ST_IDLE;
    endcase
end

always @* begin
    evSet = {`EV_W{1'b0}};
    if (state_r == ST_DONE && op_r != `OP_DATARD) begin
        evSet[`EV_DONE] = 1'b1;
        if (isArrayOp) begin
            // Cache result only trusted once the array is idle
            evSet[`EV_FAIL] = flashSt_r[`ST_FAIL] &&
                (op_r != `OP_CACHE || flashSt_r[`ST_ARRAY_IDLE]); // RULE5 RULE6 RULE8
            evSet[`EV_PREV_FAIL] = prevValid_r && flashSt_r[`ST_FAIL_PREV]; // RULE7
            evSet[`EV_PROT] = !flashSt_r[`ST_WP_N]; // RULE10
        end
    end
end

always @(posedge core_clk) begin
    if (!nrst) begin
        state_r <= ST_PWR;
        issued_r <= 1'b0;
        op_r <= `OP_STATUS;
        addrIdx_r <= 3'h0;
        col_r <= 16'h0000;
        row_r <= 24'h000000;
        data_r <= 8'h00;
        flashSt_r <= 8'h00;
        statusMode_r <= 1'b0;
        cacheSeen_r <= 1'b0;
        prevValid_r <= 1'b0;
        wpRel_r <= 1'b0;
        twbCnt_r <= 4'h0;
        chipEnN <= 1'b1;
    end else if (!supplyOk) begin
        state_r <= ST_PWR; // RULE13
        issued_r <= 1'b0;
        statusMode_r <= 1'b0;
        cacheSeen_r <= 1'b0;
        chipEnN <= 1'b1;
    end else begin
        state_r <= state_nxt;
        if (cycStart) begin
            issued_r <= 1'b1;
        end else if (cycDone) begin
            issued_r <= 1'b0;
        end
        chipEnN <= (state_nxt == ST_IDLE) || (state_nxt == ST_PWR);
        if (regWr && regAddr == `REG_ROW) row_r <= regWdata[23:0];
        if (regWr && regAddr == `REG_COL) col_r <= regWdata[15:0];
        if (regWr && regAddr == `REG_DATA && state_r == ST_IDLE) data_r <= regWdata[7:0];
        if (regWr && regAddr == `REG_CTRL) wpRel_r <= regWdata[`CTRL_WP_REL];
        if (state_r == ST_IDLE && startReq) begin
            op_r <= regWdata[`CTRL_OP_HI:`CTRL_OP_LO];
            addrIdx_r <= (regWdata[`CTRL_OP_HI:`CTRL_OP_LO] == `OP_ERASE) ? 3'h2 : 3'h0;
        end
        if (state_r == ST_ADDR && cycDone) addrIdx_r <= addrIdx_r + 3'h1;
        // Any command other than status ends status mode
        if (state_r == ST_CMD1 || state_r == ST_RDCMD) statusMode_r <= 1'b0; // RULE3
        if (state_r == ST_SCMD && cycDone) statusMode_r <= 1'b1;
        if (state_r == ST_CMD2 && cycDone) begin
            prevValid_r <= isProgOp && cacheSeen_r;
            cacheSeen_r <= (op_r == `OP_CACHE);
        end
        if (state_r == ST_CMD1 && op_r == `OP_RESET) cacheSeen_r <= 1'b0;
        twbCnt_r <= (state_r == ST_TWB) ? twbCnt_r - 4'h1 : 4'(`WB_CYC - 1);
        if (state_r == ST_SREAD && cycDone) flashSt_r <= cycRd & `ST_USED_MASK; // RULE17
        if (state_r == ST_RDDATA && cycDone) data_r <= cycRd;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power-up recovery and write protect

always @(posedge core_clk) begin
    if (!nrst) begin
        pwrCnt_r <= 11'h000;
        pwrReady_r <= 1'b0;
        wpN <= 1'b0;
    end else begin
        if (!supplyOk) begin
            pwrCnt_r <= 11'h000;
            pwrReady_r <= 1'b0;
        end else if (!pwrReady_r) begin
            if (pwrCnt_r == 11'(`RECOV_CYC - 1)) begin
                pwrReady_r <= 1'b1; // RULE14
            end else begin
                pwrCnt_r <= pwrCnt_r + 11'h001;
            end
        end
        wpN <= supplyOk && pwrReady_r && wpRel_r; // RULE15
    end
end

////////////////////////////////////////////////////////////////////////////////
// Events and register reads

evt_irq u_evt (
    .core_clk(core_clk),
    .nrst(nrst),
    .evSet(evSet),
    .clrWrite(regWr && regAddr == `REG_EVT),
    .maskWrite(regWr && regAddr == `REG_MASK),
    .wdata(regWdata[`EV_W-1:0]),
    .evStat(evStat),
    .evMask(evMask),
    .irq(irq)
);

always @(posedge core_clk) begin
    if (!nrst) begin
        regRdata <= 32'h00000000;
    end else if (regRead) begin
        case (regAddr)
            `REG_CTRL: regRdata <= {27'h0, wpRel_r, busyLine, statusMode_r, pwrReady_r,
                state_r != ST_IDLE};
            `REG_ROW: regRdata <= {8'h00, row_r};
            `REG_COL: regRdata <= {16'h0000, col_r};
            `REG_DATA: regRdata <= {24'h000000, data_r};
            `REG_FLASH_ST: regRdata <= {24'h000000, flashSt_r};
            `REG_EVT: regRdata <= {28'h0000000, evStat};
            `REG_MASK: regRdata <= {28'h0000000, evMask};
            default: regRdata <= 32'h00000000;
        endcase
    end else begin
        regRdata <= 32'h00000000;
    end
end

endmodule // nand_status_host
`default_nettype wire

// ==== rtl/nand_status_host_regs.vh ====
// Constants for the NAND status and ready host controller.
// Included by every design file; definitions only.
`ifndef NAND_STATUS_HOST_REGS_VH
`define NAND_STATUS_HOST_REGS_VH

// Clock and cycle conversion
`define CLK_NS 8
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_DN(ns) ((ns) / `CLK_NS)

// Pin timing in ns
`define T_WP_NS 12
`define T_WH_NS 10
`define T_REA_NS 20
`define T_REH_NS 10
`define T_WB_NS 100
`define T_RECOV_NS 10000
`define WR_LOW_CYC `CYC_UP(`T_WP_NS)
`define WR_HIGH_CYC `CYC_UP(`T_WH_NS)
`define RD_LOW_CYC `CYC_UP(`T_REA_NS)
`define RD_HIGH_CYC `CYC_UP(`T_REH_NS)
`define WB_CYC `CYC_DN(`T_WB_NS)
`define RECOV_CYC `CYC_UP(`T_RECOV_NS)

// Flash command codes
`define CMD_READ 8'h00
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_CONF 8'h10
`define CMD_CACHE_CONF 8'h15
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_CONF 8'hd0
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hff

// Pin cycle kinds
`define CYC_CMD 2'h0
`define CYC_ADDR 2'h1
`define CYC_WR 2'h2
`define CYC_RD 2'h3

// Software operations
`define OP_STATUS 3'h0
`define OP_RESET 3'h1
`define OP_PROG 3'h2
`define OP_ERASE 3'h3
`define OP_CACHE 3'h4
`define OP_DATARD 3'h5

// Register offsets
`define REG_CTRL 3'h0
`define REG_ROW 3'h1
`define REG_COL 3'h2
`define REG_DATA 3'h3
`define REG_FLASH_ST 3'h4
`define REG_EVT 3'h5
`define REG_MASK 3'h6

// Control fields
`define CTRL_START 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 3
`define CTRL_WP_REL 4

// Flash status byte bits
`define ST_FAIL 0
`define ST_FAIL_PREV 1
`define ST_ARRAY_IDLE 5
`define ST_READY 6
`define ST_WP_N 7
`define ST_USED_MASK 8'he3

// Event bits
`define EV_DONE 0
`define EV_FAIL 1
`define EV_PREV_FAIL 2
`define EV_PROT 3
`define EV_W 4

`endif

// ==== tb/flash_status_model.sv ====
// Behavioural flash die: status byte, ready/busy, two-step confirms.
// Assumes the bench pulls the busy line up and injects failures via failMode.
`timescale 1ns/1ps
`default_nettype none
module flash_status_model (
    input wire logic chipEnN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    input wire logic wpN,
    input wire logic [7:0] ioOut,
    input wire logic supplyOk,
    input wire logic failMode,
    input wire logic slow,
    output logic [7:0] ioIn,
    output logic busyDrvLow,
    output logic [7:0] dataLat,
    output logic [39:0] addrSh
);
    logic statusMode = 0, setupSeen = 0, cacheSeen = 0, prevValid = 0, fail = 0, prevFail = 0;
    logic rdy = 1, idl = 1;
    logic [2:0] junk = 0;
    time readyAt = 0, idleAt = 0;
    logic [7:0] stat;
    always #2 begin
        rdy = $time >= readyAt;
        idl = $time >= idleAt;
        junk = junk + 3'h3;
    end
    assign busyDrvLow = !rdy;
    // Invalid bits show a moving pattern
    assign stat = {wpN, rdy, idl, junk, prevValid ? prevFail : junk[1], idl ? fail : junk[0]};
    assign ioIn = (!chipEnN && !readStrobeN && supplyOk) ? (statusMode ? stat : dataLat ^ 8'h5a) : ~{junk, junk, junk[1:0]};
    ////////////////////////////////////////
    always @(posedge writeStrobeN) begin
        if (!chipEnN && supplyOk) begin
            if (cmdLatch) begin
                statusMode = ioOut == 8'h70;
                if (ioOut == 8'h80 || ioOut == 8'h60) setupSeen = 1;
                if ((ioOut == 8'h10 || ioOut == 8'h15 || ioOut == 8'hd0) && setupSeen) begin
                    setupSeen = 0;
                    prevValid = cacheSeen && ioOut != 8'hd0;
                    prevFail = fail;
                    fail = failMode;
                    cacheSeen = ioOut == 8'h15;
                    readyAt = $time + (slow ? 3000 : 300);
                    if (!cacheSeen && idleAt > readyAt) readyAt = idleAt;
                    idleAt = readyAt + (cacheSeen ? 2000 : 0);
                end
                if (ioOut == 8'hff) begin
                    readyAt = $time + 200;
                    idleAt = readyAt;
                end
            end else if (addrLatch) addrSh = {ioOut, addrSh[39:8]};
            else dataLat = ioOut;
        end
    end
    always @(negedge supplyOk) begin
        statusMode = 0;
        setupSeen = 0;
        readyAt = $time;
        idleAt = $time;
    end
endmodule // flash_status_model
`default_nettype wire

// ==== tb/nand_status_host_checker.sv ====
// Checker for the NAND host controller: pin sequencing and power behaviour.
// Sees only the top-level ports; bound to every nand_status_host instance.
`timescale 1ns/1ps
`default_nettype none
module nand_status_host_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chipEnN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    input wire logic wpN,
    input wire logic [7:0] ioOut,
    input wire logic ioOe,
    input wire logic busyLine,
    input wire logic supplyOk
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [11:0] upCnt_r;
    logic setup_r;
    ////////////////////////////////////////
    // Supply-good age and pending setup code
    always @(posedge core_clk) begin
        if (!nrst || !supplyOk) upCnt_r <= 12'h0;
        else if (upCnt_r != 12'hfff) upCnt_r <= upCnt_r + 12'h1;
        if (!nrst) setup_r <= 1'b0;
        else if ($fell(writeStrobeN) && cmdLatch) setup_r <= ioOut == 8'h80 || ioOut == 8'h60;
    end
    property p_up_wait; !chipEnN |-> upCnt_r >= 12'd1250; endproperty
    a_up_wait: assert property (p_up_wait) else $error("chip selected too soon");
    property p_lockout; !supplyOk |-> ##[1:2] (chipEnN && !wpN); endproperty
    a_lockout: assert property (p_lockout) else $error("no lockout on low supply");
    property p_wp_rise; $rose(wpN) |-> upCnt_r >= 12'd1250; endproperty
    a_wp_rise: assert property (p_wp_rise) else $error("write protect released early");
    property p_two_step; $fell(writeStrobeN) && cmdLatch && (ioOut == 8'h10 || ioOut == 8'h15 || ioOut == 8'hd0)
        |-> setup_r; endproperty
    a_two_step: assert property (p_two_step) else $error("confirm without setup");
    property p_busy_quiet; $fell(writeStrobeN) && !busyLine |-> cmdLatch && (ioOut == 8'h70 || ioOut == 8'hff);
        endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("write cycle while busy");
    property p_read_float; !readStrobeN |-> !ioOe && !chipEnN; endproperty
    a_read_float: assert property (p_read_float) else $error("bus driven in read");
    property p_read_len; $fell(readStrobeN) |=> !readStrobeN ##1 !readStrobeN ##1 readStrobeN; endproperty
    a_read_len: assert property (p_read_len) else $error("read strobe length");
    property p_write_len; $fell(writeStrobeN) |=> !writeStrobeN ##1 writeStrobeN; endproperty
    a_write_len: assert property (p_write_len) else $error("write strobe length");
    property p_latch_stable; $rose(writeStrobeN) |-> $stable(ioOut) && $stable(cmdLatch) && $stable(addrLatch) && ioOe;
        endproperty
    a_latch_stable: assert property (p_latch_stable) else $error("bus moved at latch edge");
endmodule // nand_status_host_checker
bind nand_status_host nand_status_host_checker i_chk (.core_clk(core_clk), .nrst(nrst), .chipEnN(chipEnN),
    .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
    .wpN(wpN), .ioOut(ioOut), .ioOe(ioOe), .busyLine(busyLine), .supplyOk(supplyOk));
`default_nettype wire

// ==== tb/tb_nand_status_host.sv ====
// Self-checking bench for the NAND host controller with a flash model.
// Reads are checked from a queue of expected values by a monitor process.
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_host_regs.vh"
module tb_nand_status_host;
    logic core_clk = 0, nrst = 0, regWrite = 0, regRead = 0, supplyOk = 1, failMode = 0, slow = 0;
    logic maskOn = 0, wpRel = 0, rdPend = 0;
    logic [2:0] regAddr = 0;
    logic [31:0] regWdata = 0, regRdata;
    logic irq, chipEnN, cmdLatch, addrLatch, writeStrobeN, readStrobeN, wpN, ioOe, busyDrvLow;
    logic [7:0] ioOut, ioIn, dataLat, dByte;
    logic [39:0] addrSh;
    logic [23:0] row;
    logic [15:0] col;
    logic [63:0] expQ[$];
    logic [63:0] e;
    int n_errors = 0, n_checks = 0, cyc = 0, seed = 31868;
    wire busyLine = !busyDrvLow;
    always #4 core_clk = ~core_clk;
    nand_status_host i_dut (.core_clk, .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq,
        .chipEnN, .cmdLatch, .addrLatch, .writeStrobeN, .readStrobeN, .wpN, .ioOut, .ioOe, .ioIn, .busyLine,
        .supplyOk);
    flash_status_model i_flash (.chipEnN, .cmdLatch, .addrLatch, .writeStrobeN, .readStrobeN, .wpN, .ioOut,
        .supplyOk, .failMode, .slow, .ioIn, .busyDrvLow, .dataLat, .addrSh);
    ////////////////////////////////////////
    task close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 0;
    endtask
    task rd(input logic [2:0] a, input logic [31:0] x, input logic [31:0] m);
        @(posedge core_clk);
        regRead <= 1;
        regAddr <= a;
        expQ.push_back({m, x});
        @(posedge core_clk);
        regRead <= 0;
    endtask
    task poll(input logic [2:0] a, input int b, input logic v);
        int i;
        for (i = 0; i < 3000; i++) begin
            rd(a, 0, 0);
            #1;
            if (regRdata[b] === v) break;
        end
        if (i == 3000) chk("poll", 1, 0);
    endtask
    task runOp(input logic [2:0] op, input logic fm, input logic [7:0] st, input logic [7:0] m, input logic [3:0] ev);
        @(posedge core_clk);
        failMode <= fm;
        wr(`REG_CTRL, {27'h0, wpRel, op, 1'b1});
        poll(`REG_EVT, `EV_DONE, 1);
        chk("irq", maskOn, irq);
        rd(`REG_FLASH_ST, st & m, m);
        rd(`REG_EVT, ev, 32'hf);
        wr(`REG_EVT, 32'hf);
        rd(`REG_EVT, 0, 32'hf);
        chk("irqClr", 0, irq);
    endtask
    always @(posedge core_clk) begin
        if (rdPend) begin
            e = expQ.pop_front();
            if (e[63:32] != 0) chk("regRdata", e[31:0], regRdata & e[63:32]);
        end
        rdPend <= regRead;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            close_out;
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1;
        rd(`REG_CTRL, 32'h9, 32'h1f);
        rd(`REG_EVT, 0, 32'hf);
        rd(`REG_MASK, 0, 32'hf);
        wr(3'h7, 32'hffffffff);
        rd(3'h7, 0, 32'hffffffff);
        poll(`REG_CTRL, 1, 1);
        row = 24'($random(seed));
        col = 16'($random(seed));
        dByte = 8'($random(seed));
        wr(`REG_ROW, {8'h0, row});
        wr(`REG_COL, {16'h0, col});
        wr(`REG_DATA, {24'h0, dByte});
        wr(`REG_MASK, 32'hf);
        maskOn = 1;
        runOp(`OP_STATUS, 0, 8'h60, 8'he1, 4'h1);
        runOp(`OP_RESET, 0, 8'h60, 8'he1, 4'h1);
        runOp(`OP_PROG, 0, 8'h60, 8'he1, 4'h9);
        chk("addr", {row, col}, addrSh);
        chk("data", dByte, dataLat);
        wpRel = 1;
        wr(`REG_CTRL, 32'h10);
        runOp(`OP_PROG, 1, 8'he1, 8'he1, 4'h3);
        runOp(`OP_ERASE, 0, 8'he0, 8'he1, 4'h1);
        runOp(`OP_CACHE, 1, 8'hc0, 8'he0, 4'h1);
        runOp(`OP_PROG, 0, 8'he2, 8'he3, 4'h5);
        wr(`REG_CTRL, {27'h0, wpRel, `OP_DATARD, 1'b1});
        poll(`REG_CTRL, 0, 0);
        rd(`REG_DATA, dByte ^ 8'h5a, 32'hff);
        wr(`REG_MASK, 0);
        maskOn = 0;
        runOp(`OP_STATUS, 0, 8'he2, 8'he3, 4'h1);
        wr(`REG_MASK, 32'hf);
        maskOn = 1;
        slow <= 1;
        wr(`REG_CTRL, {27'h0, wpRel, `OP_PROG, 1'b1});
        repeat (60) @(posedge core_clk);
        supplyOk <= 0;
        repeat (3) @(posedge core_clk);
        rd(`REG_CTRL, 32'h1, 32'h3);
        chk("wpN", 0, wpN);
        supplyOk <= 1;
        slow <= 0;
        poll(`REG_CTRL, 1, 1);
        wr(`REG_EVT, 32'hf);
        runOp(`OP_STATUS, 0, 8'h60, 8'h61, 4'h1);
        close_out;
    end
endmodule // tb_nand_status_host
`default_nettype wire
